// ---- hw/record_pkg.sv ----
// Constants, field layouts and carrier types of the record command handler.
// Assumes a single 40 MHz clock domain and an AHB-Lite register port.
package record_pkg;

  // ************************************************************
  // Record indices, slots and codes
  // ************************************************************
  localparam logic [7:0] IDX_SET_PPARAM = 8'h03;
  localparam logic [7:0] IDX_GET_PPARAM = 8'h04;
  localparam logic [7:0] IDX_RD_PARAM   = 8'h06;
  localparam logic [7:0] IDX_SET_PCFG   = 8'h08;
  localparam logic [7:0] IDX_GET_PCFG   = 8'h09;
  localparam logic [7:0] IDX_RD_ACFG    = 8'h0B;
  localparam logic [7:0] IDX_SET_LIST   = 8'h0C;
  localparam logic [7:0] IDX_NODE_SEL   = 8'h44;
  localparam logic [7:0] FUNC_SET_PPARAM = IDX_SET_PPARAM;
  localparam logic [7:0] SLOT_SEG1      = 8'h00;
  localparam logic [7:0] SLOT_SEG2      = 8'h64;
  localparam logic [7:0] SUBSLOT_ONE    = 8'h01;
  localparam logic [7:0] PN_OK          = 8'h00;
  localparam logic [7:0] PN_NOK         = 8'hFF;
  localparam logic [6:0] ERR_NONE       = 7'h00;
  localparam logic [6:0] ERR_REJECT     = 7'h01;
  localparam logic [7:0] UNUSED_BIT0    = 8'hFE;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int TAG_BIT     = 7;
  localparam int AB_BIT      = 7;
  localparam int SEL_AB_BIT  = 5;
  localparam int CTRL_GO_BIT = 31;
  localparam int STAT_DONE   = 0;
  localparam int STAT_BUSY   = 1;

  // ************************************************************
  // Register offsets and reset values
  // ************************************************************
  localparam logic [7:0]  ADDR_REQ_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_REQ_D0   = 8'h04;
  localparam logic [7:0]  ADDR_REQ_D1   = 8'h08;
  localparam logic [7:0]  ADDR_REQ_D2   = 8'h0C;
  localparam logic [7:0]  ADDR_RSP      = 8'h10;
  localparam logic [7:0]  ADDR_STATUS   = 8'h14;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [3:0]  RST_PARAM     = 4'hF;
  localparam logic [15:0] RST_CFG       = 16'h0000;
  localparam logic [5:0]  RST_NODE      = 6'h00;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic       wr;
    logic [7:0] subslot;
    logic [7:0] slot;
    logic [7:0] index;
  } req_t;

  typedef struct packed {
    logic [3:0]  cur_param;
    logic [15:0] det_cfg;
  } link_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

endpackage

// ---- hw/record_param_config_access.sv ----
// Record command handler: parameter, configuration and node list records.
// Assumes an AHB-Lite master with single word transfers and an AS-Interface
// master that reports the current parameters and detected configuration.
// Function
// R1: Parameter write: code, tag, segment, node, nibble.
// R2: Answer echoes code, tag, error, write status.
// R3: Controller selects node at index 0x44 first.
// R4: Slot 0 segment one, slot 100 segment two.
// R5: Controller always uses subslot one.
// R6: Index 0x04 reads stored permanent parameters.
// R7: Index 0x06 reads current node parameters.
// R8: Index 0x08 stores expected configuration codes.
// R9: Every write answers accepted or refused status.
// R10: Index 0x09 reads expected configuration codes.
// R11: Index 0x0B reads detected node configuration.
// R12: Index 0x0C stores configured node bitmap.
// R13: Unsupported requests refused, nothing stored changes.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module record_param_config_access
  import record_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // AS-Interface master side
  input  wire link_t [1:0]      link_in,
  output logic [1:0][5:0]       node_sel,
  output logic [1:0][63:0]      configured_node_list
);

  // ************************************************************
  // Storage
  // ************************************************************
  state_t       state_q;
  req_t         req_q;
  logic [95:0]  rqd_q;
  logic [31:0]  rsp_q;
  logic [31:0]  hrdata_q;
  logic [7:0]   pn_q;
  logic         done_q;
  logic         ap_wr_q;
  logic [7:0]   ap_addr_q;
  logic [3:0]   perm_q [2][64];
  logic [15:0]  pcfg_q [2][64];
  logic [1:0][5:0]  sel_q;
  logic [1:0][63:0] list_q;
  logic [7:0]   rb [12];
  logic         ap;
  logic         go;
  logic         fire;
  logic         seg;
  logic         valid;
  logic         ex_ok;
  logic [6:0]   ex_err;
  logic [31:0]  ex_rsp;
  logic [5:0]   cur;
  logic [5:0]   pp_node;
  logic         we_perm;
  logic         we_pcfg;
  logic         we_list;
  logic         we_sel;

  function automatic logic [31:0] rd_word(input logic [7:0] b2, input logic [7:0] b3);
    return {b3, b2, 16'h0000};
  endfunction

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  assign ap        = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q   <= ap && hwrite && hsize == HSIZE_WORD;
      ap_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ap && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_REQ_CTRL: hrdata_q <= {7'h00, req_q};
        ADDR_REQ_D0:   hrdata_q <= rqd_q[31:0];
        ADDR_REQ_D1:   hrdata_q <= rqd_q[63:32];
        ADDR_REQ_D2:   hrdata_q <= rqd_q[95:64];
        ADDR_RSP:      hrdata_q <= rsp_q;
        ADDR_STATUS:   hrdata_q <= {16'h0000, pn_q, 6'h00, state_q == ST_EXEC, done_q};
        default:       hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      rqd_q <= '0;
    end else if (ap_wr_q && state_q == ST_IDLE) begin
      unique case (ap_addr_q)
        ADDR_REQ_CTRL: req_q <= hwdata[24:0];
        ADDR_REQ_D0:   rqd_q[31:0] <= hwdata;
        ADDR_REQ_D1:   rqd_q[63:32] <= hwdata;
        ADDR_REQ_D2:   rqd_q[95:64] <= hwdata;
        default:       ;
      endcase
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // A start while a request executes is ignored.
  assign go   = ap_wr_q && ap_addr_q == ADDR_REQ_CTRL && hwdata[CTRL_GO_BIT]
                && state_q == ST_IDLE;
  assign fire = state_q == ST_EXEC;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: state_q <= go ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_q <= ST_IDLE;
      endcase
    end
  end

  // Completion sets done; a clear in the same cycle loses.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (fire) begin
      done_q <= 1'b1;
    end else if (ap_wr_q && ap_addr_q == ADDR_STATUS && hwdata[STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // ************************************************************
  // Request decode
  // ************************************************************
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      rb[i] = rqd_q[8*i +: 8];
    end
  end

  assign seg     = req_q.slot == SLOT_SEG2; // R4
  assign valid   = (req_q.slot == SLOT_SEG1 || seg) && req_q.subslot == SUBSLOT_ONE; // R13
  assign cur     = sel_q[seg];
  assign pp_node = {rb[3][AB_BIT], rb[2][4:0]};

  always_comb begin
    ex_ok   = 1'b0;
    ex_err  = ERR_REJECT;
    ex_rsp  = 32'h0000_0000;
    we_perm = 1'b0;
    we_pcfg = 1'b0;
    we_list = 1'b0;
    we_sel  = 1'b0;
    if (valid) begin
      unique case ({req_q.wr, req_q.index})
        {1'b1, IDX_SET_PPARAM}: begin
          ex_ok   = rb[0] == FUNC_SET_PPARAM && rb[2][4:0] != 5'h00; // R1
          we_perm = ex_ok;
          ex_err  = ex_ok ? ERR_NONE : ERR_REJECT;
        end
        {1'b0, IDX_GET_PPARAM}: begin
          ex_ok  = 1'b1;
          ex_rsp = rd_word({4'h0, perm_q[seg][cur]}, 8'h00); // R6
        end
        {1'b0, IDX_RD_PARAM}: begin
          ex_ok  = 1'b1;
          ex_rsp = rd_word({4'h0, link_in[seg].cur_param}, 8'h00); // R7
        end
        {1'b1, IDX_SET_PCFG}: begin
          ex_ok   = 1'b1;
          we_pcfg = 1'b1; // R8
        end
        {1'b0, IDX_GET_PCFG}: begin
          ex_ok  = 1'b1;
          ex_rsp = rd_word(pcfg_q[seg][cur][15:8], pcfg_q[seg][cur][7:0]); // R10
        end
        {1'b0, IDX_RD_ACFG}: begin
          ex_ok  = 1'b1;
          ex_rsp = rd_word(link_in[seg].det_cfg[15:8], link_in[seg].det_cfg[7:0]); // R11
        end
        {1'b1, IDX_SET_LIST}: begin
          ex_ok   = 1'b1;
          we_list = 1'b1; // R12
        end
        {1'b1, IDX_NODE_SEL}: begin
          ex_ok  = 1'b1;
          we_sel = 1'b1;
        end
        default: ex_ok = 1'b0; // R13
      endcase
    end
    if (req_q.wr && req_q.index == IDX_SET_PPARAM) begin
      ex_rsp = {8'h00, ex_ok ? PN_OK : PN_NOK, rb[1][TAG_BIT], ex_err, FUNC_SET_PPARAM}; // R2
    end
  end

  // ************************************************************
  // Answer
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_q <= 32'h0000_0000;
      pn_q  <= PN_OK;
    end else if (fire) begin
      rsp_q <= ex_rsp;
      pn_q  <= ex_ok ? PN_OK : PN_NOK; // R9
    end
  end

  // ************************************************************
  // Stored images
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int s = 0; s < 2; s++) begin
        for (int n = 0; n < 64; n++) begin
          perm_q[s][n] <= RST_PARAM;
          pcfg_q[s][n] <= RST_CFG;
        end
      end
    end else if (fire) begin
      if (we_perm) begin
        perm_q[seg][pp_node] <= rb[4][3:0]; // R1
      end
      if (we_pcfg) begin
        pcfg_q[seg][cur] <= {rb[2], rb[3]}; // R8
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      list_q <= '0;
      sel_q  <= {RST_NODE, RST_NODE};
    end else if (fire) begin
      if (we_list) begin
        list_q[seg] <= {rb[9], rb[8], rb[7], rb[6] & UNUSED_BIT0,
                        rb[5], rb[4], rb[3], rb[2] & UNUSED_BIT0}; // R12
      end
      if (we_sel) begin
        sel_q[seg] <= rb[2][SEL_AB_BIT:0]; // R4
      end
    end
  end

  assign node_sel             = sel_q;
  assign configured_node_list = list_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_start_to_done: assert property (go |=> fire ##1 done_q && !fire) // R9
    else $error("request did not complete in two cycles");
  a_echo_code: assert property (fire && req_q.wr && req_q.index == IDX_SET_PPARAM // R2
    |=> rsp_q[7:0] == FUNC_SET_PPARAM && rsp_q[15] == $past(rb[1][TAG_BIT]))
    else $error("parameter answer lost code or tag");
  a_refuse_keep: assert property (fire && !valid // R13
    |=> pn_q == PN_NOK && $stable(list_q) && $stable(sel_q))
    else $error("refused request changed state");
  a_perm_store: assert property (fire && we_perm // R1
    |=> perm_q[$past(seg)][$past(pp_node)] == $past(rb[4][3:0]))
    else $error("permanent parameter not stored");
  a_perm_read: assert property (fire && valid && !req_q.wr && req_q.index == IDX_GET_PPARAM // R6
    |=> rsp_q == {8'h00, 4'h0, $past(perm_q[seg][cur]), 16'h0000})
    else $error("permanent parameter read wrong");
  a_cur_read: assert property (fire && valid && !req_q.wr && req_q.index == IDX_RD_PARAM // R7
    |=> rsp_q[23:16] == {4'h0, $past(link_in[seg].cur_param)})
    else $error("current parameter read wrong");
  a_cfg_store: assert property (fire && we_pcfg // R8
    |=> pcfg_q[$past(seg)][$past(cur)] == {$past(rb[2]), $past(rb[3])})
    else $error("expected configuration not stored");
  a_cfg_round: assert property (fire && valid && !req_q.wr && req_q.index == IDX_GET_PCFG // R10
    |=> rsp_q[31:16] == {$past(pcfg_q[seg][cur][7:0]), $past(pcfg_q[seg][cur][15:8])})
    else $error("expected configuration readback wrong");
  a_act_read: assert property (fire && valid && !req_q.wr && req_q.index == IDX_RD_ACFG // R11
    |=> rsp_q[31:16] == {$past(link_in[seg].det_cfg[7:0]), $past(link_in[seg].det_cfg[15:8])})
    else $error("detected configuration read wrong");
  a_list_store: assert property (fire && we_list // R12
    |=> list_q[$past(seg)][7:0] == ($past(rb[2]) & UNUSED_BIT0) && !list_q[$past(seg)][32])
    else $error("configured node list not stored");
  a_slot_route: assert property (fire && we_sel && seg // R4
    |=> sel_q[1] == $past(rb[2][5:0]) && $stable(sel_q[0]))
    else $error("node selection went to wrong segment");

  c_param_write: cover property (fire && we_perm);
  c_list_write:  cover property (fire && we_list ##[1:20] fire && !valid);
  c_cfg_round:   cover property (fire && we_pcfg ##[2:20] fire && req_q.index == IDX_GET_PCFG);

endmodule

// ---- testbench/asi_link_model.sv ----
// Far-side model: the link master reporting the state of the selected node.
// Assumes node_sel from the handler; answers at once, as a level.
`timescale 1ns/10ps
module asi_link_model
  import record_pkg::*;
(
  // Node selection from the handler
  input  wire logic [1:0][5:0] node_sel,
  // Reported node state per segment
  output link_t [1:0]          link_in
);
  // Each answer depends on the segment and on the node, cur_param on node bits 3:0 only, so that a
  // wrong segment, or a node wrong in the bits an answer uses, shows up as a wrong answer.
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      link_in[s].cur_param = node_sel[s][3:0] ^ {s[0], 3'b101};
      link_in[s].det_cfg   = {node_sel[s][3:0] ^ 4'hA, s[0], 1'b0, node_sel[s], 4'h3};
    end
  end
endmodule

// ---- testbench/record_param_config_access_tb.sv ----
// Self-checking bench of the record handler, driven over AHB-Lite.
// Assumes the link model on the far side and a zero-wait-state slave.
`timescale 1ns/10ps
module record_param_config_access_tb;
  import record_pkg::*;
  logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_dp;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, q;
  link_t [1:0]      link_in;
  logic [1:0][5:0]  node_sel;
  logic [1:0][63:0] configured_node_list;
  logic [31:0]      exp_q[$];
  int               n_mismatch, tests_run, cyc;

  assign hready = hreadyout;
  record_param_config_access dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_in(link_in), .node_sel(node_sel), .configured_node_list(configured_node_list));
  asi_link_model link_u (.node_sel(node_sel), .link_in(link_in));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ************************************************************
  // Read data watcher
  // ************************************************************
  always @(negedge hclk) begin
    if (rd_dp) begin
      cmp("hrdata", {32'h0, exp_q.pop_front()}, {32'h0, hrdata});
      cmp("hresp", 64'h0, {63'h0, hresp});
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ************************************************************
  // Bus and record tasks
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic c, input logic [31:0] e);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel   <= 1'b1;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp  <= c;
    if (c) exp_q.push_back(e);
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    rd_dp <= 1'b0;
  endtask

  task automatic rec(input logic [7:0] idx, input logic [7:0] sl, input logic [7:0] sub,
                     input logic wr, input logic [95:0] b, input logic [7:0] pn,
                     input logic ck, input logic [31:0] rsp);
    int n;
    for (int i = 0; i < 3; i++) bus(1'b1, 8'h04 + 8'(4 * i), b[32*i +: 32], 1'b0, 32'h0);
    bus(1'b1, ADDR_REQ_CTRL, {1'b1, 6'h00, wr, sub, sl, idx}, 1'b0, 32'h0);
    n = 0;
    q = 32'h0;
    while (q[STAT_DONE] !== 1'b1 && n < 50) begin
      bus(1'b0, ADDR_STATUS, 32'h0, 1'b0, 32'h0);
      if (n == 0) cmp("busy", 64'h1, {63'h0, q[STAT_BUSY]});
      n++;
    end
    cmp("done", 64'h1, {63'h0, q[STAT_DONE]});
    bus(1'b1, ADDR_STATUS, 32'h1, 1'b0, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0, 1'b1, {16'h0, pn, 8'h00});
    if (ck) bus(1'b0, ADDR_RSP, 32'h0, 1'b1, rsp);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [5:0]  nd[2];
    logic [3:0]  p[2];
    logic [63:0] l[2];
    logic [15:0] c, d;
    logic [7:0]  sl;
    logic        t;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    void'($urandom(32'hF871));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmp("node_sel", 64'h0, {52'h0, node_sel});
    bus(1'b0, ADDR_REQ_CTRL, 32'h0, 1'b1, 32'h0);
    bus(1'b0, 8'h20, 32'h0, 1'b1, 32'h0);
    for (int s = 0; s < 2; s++) begin
      sl = s ? SLOT_SEG2 : SLOT_SEG1;
      nd[s] = {1'($urandom), 5'($urandom_range(31, 1))};
      p[s] = 4'($urandom);
      t = 1'($urandom);
      rec(IDX_NODE_SEL, sl, SUBSLOT_ONE, 1'b1, {72'h0, 2'b00, nd[s], 16'h0}, PN_OK, 1'b0, 32'h0);
      cmp("node_sel", {58'h0, nd[s]}, {58'h0, node_sel[s]});
      rec(IDX_SET_PPARAM, sl, SUBSLOT_ONE, 1'b1, {56'h0, 4'h0, p[s], nd[s][5], 7'h00,
          3'b000, nd[s][4:0], t, 6'h00, s[0], FUNC_SET_PPARAM}, PN_OK, 1'b1,
          {8'h00, PN_OK, t, ERR_NONE, FUNC_SET_PPARAM});
      rec(IDX_GET_PPARAM, sl, SUBSLOT_ONE, 1'b0, 96'h0, PN_OK, 1'b1, {12'h000, p[s], 16'h0});
      rec(IDX_RD_PARAM, sl, SUBSLOT_ONE, 1'b0, 96'h0, PN_OK, 1'b1,
          {12'h000, nd[s][3:0] ^ {s[0], 3'b101}, 16'h0});
      c = 16'($urandom);
      rec(IDX_SET_PCFG, sl, SUBSLOT_ONE, 1'b1, {64'h0, c[7:0], c[15:8], 16'h0}, PN_OK, 1'b0,
          32'h0);
      rec(IDX_GET_PCFG, sl, SUBSLOT_ONE, 1'b0, 96'h0, PN_OK, 1'b1, {c[7:0], c[15:8], 16'h0});
      d = {nd[s][3:0] ^ 4'hA, s[0], 1'b0, nd[s], 4'h3};
      rec(IDX_RD_ACFG, sl, SUBSLOT_ONE, 1'b0, 96'h0, PN_OK, 1'b1, {d[7:0], d[15:8], 16'h0});
      l[s] = {$urandom, $urandom};
      rec(IDX_SET_LIST, sl, SUBSLOT_ONE, 1'b1, {16'h0, l[s], 16'h0}, PN_OK, 1'b0, 32'h0);
      cmp("list", {l[s][63:33], 1'b0, l[s][31:1], 1'b0}, configured_node_list[s]);
    end
    rec(IDX_GET_PPARAM, 8'h05, SUBSLOT_ONE, 1'b0, 96'h0, PN_NOK, 1'b1, 32'h0);
    rec(IDX_SET_PPARAM, SLOT_SEG1, 8'h02, 1'b1, {56'h0, 4'h0, ~p[0], nd[0][5], 7'h00,
        3'b000, nd[0][4:0], 8'h80, FUNC_SET_PPARAM}, PN_NOK, 1'b1,
        {8'h00, PN_NOK, 1'b1, ERR_REJECT, FUNC_SET_PPARAM});
    for (int k = 0; k < 2; k++) begin
      rec(IDX_SET_PPARAM, SLOT_SEG1, SUBSLOT_ONE, 1'b1, {56'h0, 4'h0, ~p[0], nd[0][5], 7'h00,
          k ? {3'b000, nd[0][4:0]} : 8'h00, 8'h80, k ? 8'h05 : FUNC_SET_PPARAM}, PN_NOK, 1'b1,
          {8'h00, PN_NOK, 1'b1, ERR_REJECT, FUNC_SET_PPARAM});
    end
    rec(8'h07, SLOT_SEG1, SUBSLOT_ONE, 1'b1, {16'h0, ~l[0], 16'h0}, PN_NOK, 1'b1, 32'h0);
    rec(IDX_SET_LIST, SLOT_SEG1, SUBSLOT_ONE, 1'b0, 96'h0, PN_NOK, 1'b1, 32'h0);
    rec(IDX_GET_PPARAM, SLOT_SEG1, SUBSLOT_ONE, 1'b0, 96'h0, PN_OK, 1'b1,
        {12'h000, p[0], 16'h0});
    cmp("list", {l[0][63:33], 1'b0, l[0][31:1], 1'b0}, configured_node_list[0]);
    cmp("node_sel", {58'h0, nd[0]}, {58'h0, node_sel[0]});
    report_and_stop();
  end
endmodule
